// file: dv/host_terminal_model.sv
// host terminal model: sends record characters and collects echoes
module host_terminal_model (
    input  wire logic       i_ref_clk,
    output logic            o_rx_valid,
    output logic [7:0]      o_rx_data,
    input  wire logic       i_rx_ready,
    input  wire logic       i_tx_valid,
    input  wire logic [7:0] i_tx_data,
    output logic            o_tx_ready,
    output logic            o_tx_idle
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] echoes[$];
    logic [2:0] pace_q = 3'h0;
    logic [1:0] busy_q = 2'h0;
    initial begin
        o_rx_valid = 1'b0;
        o_rx_data  = 8'h00;
        o_tx_ready = 1'b0;
        o_tx_idle  = 1'b1;
    end
    // =====================================================
    // echo sink: stalls half the time, shifter busy after each take
    always @(posedge i_ref_clk) begin
        if (i_tx_valid && o_tx_ready) begin
            echoes.push_back(i_tx_data);
            busy_q = 2'h3;
        end else if (busy_q != 2'h0) begin
            busy_q = busy_q - 2'h1;
        end
        #1;
        o_tx_idle  <= (busy_q == 2'h0);
        pace_q     <= pace_q + 3'h1;
        o_tx_ready <= pace_q[1];
    end
    // =====================================================
    // one character, held until taken, then line shows its inverse
    task automatic send(input logic [7:0] c);
        @(posedge i_ref_clk);
        #1;
        o_rx_valid = 1'b1;
        o_rx_data  = c;
        do @(posedge i_ref_clk); while (i_rx_ready !== 1'b1);
        #1;
        o_rx_valid = 1'b0;
        o_rx_data  = ~c;
    endtask
endmodule

// file: dv/uart_boot_record_loader_test.sv
// self-checking bench of the boot-record loader against a host model
`include "boot_loader_consts.svh"
module uart_boot_record_loader_test;
    import boot_loader_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, srst = 1'b1, brk_n = 1'b0, emu = 1'b1;
    logic        u1_v, u1_r, u2_r, tx_v, tx_sel, tx_r, tx_idle, pin_en;
    logic        u2_v = 1'b0, wr_r = 1'b0, ex_done = 1'b0, wr_v, ex_v, ex_ib;
    logic [7:0]  u1_d, tx_d, ib_d, u2_d = 8'hA5;
    logic [4:0]  ib_a = 5'h00;
    logic [15:0] baud, echo_baud;
    logic [31:0] sp, pc, ex_a;
    op_mode_t    mode;
    frame_t      frame;
    mem_wr_t     wr;
    mem_wr_t     wrs[$];
    logic [32:0] exs[$];
    logic        u2_taken = 1'b0;
    int          miscompares = 0, checks = 0;

    always #2 clk = ~clk;

    boot_record_loader DUT (.i_ref_clk(clk), .i_srst(srst),
        .i_boot_break_request_n(brk_n), .i_emu_request(emu),
        .i_uart1_rx_valid(u1_v), .i_uart1_rx_data(u1_d),
        .o_uart1_rx_ready(u1_r), .i_uart2_rx_valid(u2_v),
        .i_uart2_rx_data(u2_d), .o_uart2_rx_ready(u2_r),
        .o_tx_valid(tx_v), .o_tx_data(tx_d), .o_tx_sel(tx_sel),
        .i_tx_ready(tx_r), .i_tx_idle(tx_idle),
        .o_second_uart_tx_pin_en(pin_en), .o_mode(mode),
        .o_reset_sp(sp), .o_reset_pc(pc), .o_baud_div(baud),
        .o_frame(frame), .o_mem_wr_valid(wr_v), .o_mem_wr(wr),
        .i_mem_wr_ready(wr_r), .o_exec_valid(ex_v), .o_exec_addr(ex_a),
        .o_exec_ibuf(ex_ib), .i_exec_done(ex_done),
        .i_ibuf_rd_addr(ib_a), .o_ibuf_rd_data(ib_d));

    host_terminal_model h (.i_ref_clk(clk), .o_rx_valid(u1_v),
        .o_rx_data(u1_d), .i_rx_ready(u1_r), .i_tx_valid(tx_v),
        .i_tx_data(tx_d), .o_tx_ready(tx_r), .o_tx_idle(tx_idle));

    // =====================================================
    // monitors: byte writes, execution pulses, echo rate
    always @(posedge clk) begin
        if (wr_v && wr_r) wrs.push_back(wr);
        if (ex_v) exs.push_back({ex_ib, ex_a});
        if (u2_v && u2_r) u2_taken = 1'b1;
        if (tx_v && tx_r && tx_d == 8'h38) echo_baud = baud;
        #1 wr_r <= ~wr_r;
    end

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // sends a string, then waits for and compares every echo
    task automatic rec(input string s);
        for (int i = 0; i < s.len(); i++) h.send(s[i]);
        for (int n = 0; n < 3000 && h.echoes.size() < s.len(); n++)
            @(posedge clk);
        #1;
        chk(h.echoes.size(), s.len());
        for (int i = 0; i < h.echoes.size(); i++)
            chk(h.echoes[i], s[i]);
        h.echoes.delete();
    endtask

    task automatic wchk(input logic [31:0] a, input logic [7:0] d);
        mem_wr_t w = wrs.size() ? wrs.pop_front() : 'x;
        chk({w.addr, w.data}, {a, d});
    endtask

    task automatic t_link;
        chk(mode, MODE_BOOT);
        chk({sp, pc}, {`RST_SP_VEC, `RST_PC_VEC});
        chk(frame, {4'h8, 1'b0, 2'h1});
        chk(pin_en, 1'b0);
        h.send(8'h41);
        for (int n = 0; n < 3000 && h.echoes.size() < 2; n++)
            @(posedge clk);
        #1;
        chk({h.echoes[0], h.echoes[1]}, 16'h4041);
        h.echoes.delete();
        chk({tx_sel, baud}, {1'b0, 16'h0126});
        u2_v = 1'b1;
    endtask

    task automatic t_records;
        rec("0000400002ABCD\r");
        wchk(32'h0000_4000, 8'hAB);
        wchk(32'h0000_4001, 8'hCD);
        rec("1234 000040FF01EE/5\r");
        wchk(32'h0000_40FF, 8'hEE);
        chk(wrs.size(), 0);
        rec("FFFFF43B01CF\r");
        wchk(32'hFFFF_F43B, 8'hCF);
        chk(pin_en, 1'b1);
    endtask

    task automatic t_baud;
        rec("FFFFF9020100\r");
        wchk(32'hFFFF_F902, 8'h00);
        chk(baud, 16'h0026);
        rec("FFFFF9030138\r");
        wchk(32'hFFFF_F903, 8'h38);
        chk(baud, 16'h0038);
    endtask

    task automatic t_ibuf;
        logic [7:0] exp[4] = '{8'h12, 8'h34, 8'h4E, 8'h71};
        rec("FFFFFFC0021234\r");
        wchk(32'hFFFF_FFC0, 8'h12);
        wchk(32'hFFFF_FFC1, 8'h34);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            #1 ib_a = i[4:0];
            @(posedge clk);
            #1 chk(ib_d, exp[i]);
        end
        rec("FFFFFFC000");
        for (int n = 0; n < 50 && exs.size() == 0; n++) @(posedge clk);
        chk(exs.size() ? exs.pop_front() : 'x, {1'b1, 32'hFFFF_FFC0});
        @(posedge clk);
        #1 ex_done = 1'b1;
        @(posedge clk);
        #1 ex_done = 1'b0;
        rec("\r");
        rec("0000400000");
        for (int n = 0; n < 50 && exs.size() == 0; n++) @(posedge clk);
        chk(exs.size() ? exs.pop_front() : 'x, {1'b0, 32'h0000_4000});
        chk(u2_taken, 1'b0);
    endtask

    // reset again with the strap released: emulation mode, loader idle
    task automatic t_noboot;
        @(posedge clk);
        #1 srst = 1'b1;
        brk_n = 1'b1;
        emu   = 1'b1;
        repeat (2) @(posedge clk);
        #1 srst = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk(mode, MODE_EMU);
        chk({u1_r, u2_r}, 2'b00);
    endtask

    task automatic close_out;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        close_out();
    end

    initial begin
        repeat (8) @(posedge clk);
        #1;
        srst  = 1'b0;
        brk_n = 1'b1;
        emu   = 1'b0;
        t_link();
        t_records();
        t_baud();
        chk(echo_baud, 16'h0038);
        t_ibuf();
        t_noboot();
        close_out();
    end
endmodule

// file: rtl/boot_record_loader.sv
// boot-record loader: link setup, record parsing, writes, execution, echo
`include "boot_loader_consts.svh"
module boot_record_loader
    import boot_loader_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_srst,
    input  wire logic        i_boot_break_request_n,
    input  wire logic        i_emu_request,
    input  wire logic        i_uart1_rx_valid,
    input  wire logic [7:0]  i_uart1_rx_data,
    output logic             o_uart1_rx_ready,
    input  wire logic        i_uart2_rx_valid,
    input  wire logic [7:0]  i_uart2_rx_data,
    output logic             o_uart2_rx_ready,
    output logic             o_tx_valid,
    output logic [7:0]       o_tx_data,
    output logic             o_tx_sel,
    input  wire logic        i_tx_ready,
    input  wire logic        i_tx_idle,
    output logic             o_second_uart_tx_pin_en,
    output op_mode_t         o_mode,
    output logic [31:0]      o_reset_sp,
    output logic [31:0]      o_reset_pc,
    output logic [15:0]      o_baud_div,
    output frame_t           o_frame,
    output logic             o_mem_wr_valid,
    output mem_wr_t          o_mem_wr,
    input  wire logic        i_mem_wr_ready,
    output logic             o_exec_valid,
    output logic [31:0]      o_exec_addr,
    output logic             o_exec_ibuf,
    input  wire logic        i_exec_done,
    input  wire logic [4:0]  i_ibuf_rd_addr,
    output logic [7:0]       o_ibuf_rd_data
);
    // ========================================================
    // state
    ld_state_t   st_q;
    phase_t      ph_q;
    logic        boot_q;
    logic        sel_q;
    logic [7:0]  chr_q;
    logic [39:0] acc_q;
    logic [3:0]  hdr_q;
    logic [7:0]  left_q;
    logic        half_q;
    logic [3:0]  hi_q;
    logic [31:0] wa_q;
    logic        xpend_q;
    logic [7:0]  pjsel_q;
    logic [7:0]  ibuf_q [`IBUF_BYTES];
    localparam logic [15:0] nop_pair = `IBUF_NOP;

    // ========================================================
    // decode
    wire        f_in_ready;
    wire        f_out_valid;
    wire [7:0]  f_out_data;
    wire [18:0] ibuf_page = 19'(`IBUF_BASE >> 5);
    wire        c_dig   = (chr_q >= 8'h30) && (chr_q <= 8'h39);
    wire        c_alpha = (chr_q >= 8'h41) && (chr_q <= 8'h46);
    wire        c_hex   = c_dig || c_alpha;
    wire        c_low   = (chr_q < `CHAR_MIN);
    wire [3:0]  nib     = c_dig ? chr_q[3:0] : 4'(chr_q[3:0] + 4'h9);
    wire [7:0]  cnt_new = {acc_q[3:0], nib};
    wire [31:0] adr_new = acc_q[35:4];
    wire [7:0]  byte_new = {hi_q, nib};
    wire        rx_take1 = i_uart1_rx_valid && o_uart1_rx_ready;
    wire        rx_take2 = i_uart2_rx_valid && o_uart2_rx_ready;
    wire        rx_take  = rx_take1 || rx_take2;
    wire [7:0]  rx_data  = rx_take1 ? i_uart1_rx_data : i_uart2_rx_data;
    wire        wr_take  = o_mem_wr_valid && i_mem_wr_ready;
    wire        wa_ibuf  = (o_mem_wr.addr[23:5] == ibuf_page);
    wire [4:0]  wa_ofs   = o_mem_wr.addr[4:0];
    wire        wa_bhi   = (o_mem_wr.addr == `BAUD_HI_ADDR);
    wire        wa_blo   = (o_mem_wr.addr == `BAUD_LO_ADDR);
    wire        wa_pj    = (o_mem_wr.addr == `PJSEL_ADDR);
    wire        ack_st   = (st_q == S_ACK);
    wire        push     = (ack_st || st_q == S_ECHO) && f_in_ready;
    wire [7:0]  push_d   = ack_st ? `CHAR_ACK : chr_q;
    wire        tx_empty = !f_out_valid && !o_tx_valid && i_tx_idle;
    wire        tx_load  = !o_tx_valid || i_tx_ready;
    wire        f_pop    = f_out_valid && tx_load;

    // ========================================================
    // echo buffer
    echo_fifo #(.WIDTH(8), .DEPTH(`ECHO_DEPTH)) u_echo (
        .i_ref_clk   (i_ref_clk),
        .i_srst      (i_srst),
        .i_in_valid  (push),
        .i_in_data   (push_d),
        .o_in_ready  (f_in_ready),
        .o_out_valid (f_out_valid),
        .o_out_data  (f_out_data),
        .i_out_ready (tx_load)
    );

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_tx_valid <= 1'b0;
            o_tx_data  <= 8'h00;
        end else if (tx_load) begin
            o_tx_valid <= f_out_valid;
            o_tx_data  <= f_out_data;
        end
    end

    // ========================================================
    // mode and reset vectors
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            boot_q <= !i_boot_break_request_n;
            o_mode <= !i_boot_break_request_n ? MODE_BOOT :
                      i_emu_request ? MODE_EMU : MODE_NORMAL;
            o_reset_sp <= `RST_SP_VEC;
            o_reset_pc <= `RST_PC_VEC;
            o_frame    <= '{`FRAME_DATA_BITS, 1'b0, `FRAME_STOP_BITS};
        end
    end

    // ========================================================
    // instruction buffer
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            for (int i = 0; i < `IBUF_BYTES; i++) begin
                ibuf_q[i] <= i[0] ? nop_pair[7:0] : nop_pair[15:8];
            end
        end else if (wr_take && wa_ibuf) begin
            ibuf_q[wa_ofs] <= o_mem_wr.data;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        o_ibuf_rd_data <= ibuf_q[i_ibuf_rd_addr];
    end

    // ========================================================
    // shadowed internal registers
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_baud_div <= `BAUD_INIT;
            pjsel_q    <= `PJSEL_RST;
            o_second_uart_tx_pin_en <= 1'b0;
        end else begin
            if (st_q == S_LINK && rx_take) begin
                o_baud_div <= (rx_data & `CAL_MASK) == 8'h00 ?
                              `BAUD_LINK_32K : `BAUD_LINK_38K;
            end else if (st_q == S_BAUD && tx_empty) begin
                if (wa_bhi) o_baud_div[15:8] <= o_mem_wr.data;
                if (wa_blo) o_baud_div[7:0]  <= o_mem_wr.data;
            end
            if (wr_take && wa_pj) begin
                pjsel_q <= o_mem_wr.data;
                o_second_uart_tx_pin_en <=
                    !o_mem_wr.data[`PJSEL_TX2_BIT];
            end
        end
    end

    // ========================================================
    // loader sequence
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            st_q    <= S_OFF;
            sel_q   <= 1'b0;
            chr_q   <= 8'h00;
            o_tx_sel <= 1'b0;
            xpend_q <= 1'b0;
            o_exec_valid <= 1'b0;
            o_exec_addr  <= 32'h0000_0000;
            o_exec_ibuf  <= 1'b0;
        end else begin
            o_exec_valid <= 1'b0;
            case (st_q)
                S_OFF: begin
                    if (boot_q) st_q <= S_LINK;
                end
                S_LINK: begin
                    if (rx_take) begin
                        sel_q    <= !rx_take1;
                        o_tx_sel <= !rx_take1;
                        chr_q    <= rx_data;
                        st_q     <= S_ACK;
                    end
                end
                S_ACK: begin
                    if (f_in_ready) st_q <= S_ECHO;
                end
                S_ECHO: begin
                    if (f_in_ready) begin
                        st_q    <= xpend_q ? S_EXEC : S_RX;
                        xpend_q <= 1'b0;
                    end
                end
                S_RX: begin
                    if (rx_take) begin
                        chr_q <= rx_data;
                        st_q  <= S_PROC;
                    end
                end
                S_PROC: begin
                    if (c_hex && ph_q == PH_HDR && hdr_q == `HDR_NIBBLES &&
                        cnt_new == 8'h00) begin
                        xpend_q     <= 1'b1;
                        o_exec_addr <= adr_new;
                        o_exec_ibuf <= (adr_new[23:5] == ibuf_page);
                    end
                    st_q <= (c_hex && ph_q == PH_DATA && half_q) ?
                            S_WR : S_ECHO;
                end
                S_WR: begin
                    if (wr_take) begin
                        st_q <= (wa_bhi || wa_blo) ? S_BAUD : S_ECHO;
                    end
                end
                S_BAUD: begin
                    if (tx_empty) st_q <= S_ECHO;
                end
                S_EXEC: begin
                    o_exec_valid <= 1'b1;
                    st_q <= o_exec_ibuf ? S_XWAIT : S_GONE;
                end
                S_XWAIT: begin
                    if (i_exec_done) st_q <= S_RX;
                end
                S_GONE: begin
                    st_q <= S_GONE;
                end
                default: begin
                    st_q <= S_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_uart1_rx_ready <= 1'b0;
            o_uart2_rx_ready <= 1'b0;
        end else begin
            o_uart1_rx_ready <= !rx_take &&
                ((st_q == S_LINK) || (st_q == S_RX && !sel_q));
            o_uart2_rx_ready <= !rx_take &&
                ((st_q == S_LINK) || (st_q == S_RX && sel_q));
        end
    end

    // ========================================================
    // record assembly
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            ph_q   <= PH_HDR;
            acc_q  <= 40'h00_0000_0000;
            hdr_q  <= 4'h0;
            left_q <= 8'h00;
            half_q <= 1'b0;
            hi_q   <= 4'h0;
            wa_q   <= 32'h0000_0000;
            o_mem_wr_valid <= 1'b0;
            o_mem_wr <= '0;
        end else begin
            if (wr_take) o_mem_wr_valid <= 1'b0;
            if (st_q == S_PROC) begin
                if (!c_hex || c_low) begin
                    ph_q  <= PH_HDR;
                    hdr_q <= 4'h0;
                    acc_q <= 40'h00_0000_0000;
                end else if (ph_q == PH_HDR) begin
                    acc_q <= {acc_q[35:0], nib};
                    hdr_q <= hdr_q + 4'h1;
                    if (hdr_q == `HDR_NIBBLES) begin
                        wa_q   <= adr_new;
                        left_q <= cnt_new;
                        half_q <= 1'b0;
                        ph_q   <= (cnt_new == 8'h00) ? PH_SKIP : PH_DATA;
                    end
                end else if (ph_q == PH_DATA) begin
                    half_q <= !half_q;
                    if (!half_q) begin
                        hi_q <= nib;
                    end else begin
                        o_mem_wr_valid <= 1'b1;
                        o_mem_wr <= '{wa_q, byte_new};
                        wa_q   <= wa_q + 32'h0000_0001;
                        left_q <= left_q - 8'h01;
                        if (left_q == 8'h01) ph_q <= PH_SKIP;
                    end
                end
            end
        end
    end

    // ========================================================
    // checks
    property p_boot_prio;
        @(posedge i_ref_clk) disable iff (i_srst)
        boot_q |-> o_mode == MODE_BOOT;
    endproperty
    a_boot_prio: assert property (p_boot_prio)
        else $error("boot mode not given priority");

    sequence s_link_take;
        st_q == S_LINK && rx_take;
    endsequence
    sequence s_ack_push;
        push && push_d == `CHAR_ACK;
    endsequence
    property p_link_ack;
        @(posedge i_ref_clk) disable iff (i_srst)
        s_link_take ##1 f_in_ready |-> s_ack_push;
    endproperty
    a_link_ack: assert property (p_link_ack)
        else $error("acknowledge not pushed after link");

    property p_echo_kept;
        @(posedge i_ref_clk) disable iff (i_srst)
        (st_q == S_RX && rx_take) |-> ##1 st_q == S_PROC ##1
            (st_q == S_ECHO || st_q == S_WR);
    endproperty
    a_echo_kept: assert property (p_echo_kept)
        else $error("received character not routed to echo");

    property p_low_restart;
        @(posedge i_ref_clk) disable iff (i_srst)
        (st_q == S_PROC && !c_hex) |=> ph_q == PH_HDR && hdr_q == 4'h0;
    endproperty
    a_low_restart: assert property (p_low_restart)
        else $error("non-hex character did not restart record");

    property p_wr_ascend;
        @(posedge i_ref_clk) disable iff (i_srst)
        (st_q == S_PROC && c_hex && ph_q == PH_DATA && half_q) |=>
            o_mem_wr_valid && o_mem_wr.addr == $past(wa_q) &&
            wa_q == $past(wa_q) + 32'h1;
    endproperty
    a_wr_ascend: assert property (p_wr_ascend)
        else $error("record bytes not written to ascending addresses");

    property p_tx2_off;
        @(posedge i_ref_clk) disable iff (i_srst)
        o_second_uart_tx_pin_en |-> !pjsel_q[`PJSEL_TX2_BIT];
    endproperty
    a_tx2_off: assert property (p_tx2_off)
        else $error("second tx enabled while select bit set");

    property p_exec_pulse;
        @(posedge i_ref_clk) disable iff (i_srst)
        o_exec_valid |-> $past(st_q) == S_EXEC && ph_q == PH_SKIP &&
            left_q == 8'h00;
    endproperty
    a_exec_pulse: assert property (p_exec_pulse)
        else $error("execution started without zero-count record");

    property p_ibuf_return;
        @(posedge i_ref_clk) disable iff (i_srst)
        (st_q == S_XWAIT && i_exec_done) |=> st_q == S_RX;
    endproperty
    a_ibuf_return: assert property (p_ibuf_return)
        else $error("loader not resumed after buffer execution");

    property p_baud_quiet;
        @(posedge i_ref_clk) disable iff (i_srst)
        $changed(o_baud_div) && $past(st_q) == S_BAUD |->
            $past(tx_empty);
    endproperty
    a_baud_quiet: assert property (p_baud_quiet)
        else $error("baud changed while echoes still queued");

    property p_one_port;
        @(posedge i_ref_clk) disable iff (i_srst)
        st_q == S_RX |-> !(o_uart1_rx_ready && o_uart2_rx_ready);
    endproperty
    a_one_port: assert property (p_one_port)
        else $error("both ports read after port selection");
endmodule

// file: rtl/echo_fifo.sv
// synchronous valid/ready fifo for echo characters
module echo_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             i_ref_clk,
    input  wire logic             i_srst,
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [AW:0]      cnt_q;
    wire              push = i_in_valid && o_in_ready;
    wire              pop  = o_out_valid && i_out_ready;

    assign o_in_ready  = (cnt_q != DEPTH[AW:0]);
    assign o_out_valid = (cnt_q != '0);
    assign o_out_data  = mem_q[rp_q];

    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem_q[wp_q] <= i_in_data;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wp_q <= wp_q + AW'(1);
            if (pop)  rp_q <= rp_q + AW'(1);
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// file: shared/boot_loader_consts.svh
// constants of the boot-record loader
// Function
// - boot-loading mode outranks emulation and normal modes
// - boot mode supplies stack and program counter vectors, then runs loader
// - record is 4-byte address, 1-byte count, then count data bytes
// - nonzero-count record stores its bytes from its address, registers included
// - zero-count record starts execution at its address
// - execution at instruction buffer runs it, then loader resumes; pad with nop
// - initial framing is 19200 bps, 8 data bits, no parity, 1 stop
// - first UART holding a character becomes the session port
// - first character picks crystal baud setting and is not downloaded
// - on link, send at-sign acknowledge, then echo first character
// - second UART transmit stays off until port J select bit 5 clears
// - baud divider holds 0x0126 after link (0x0107 if first character bit 7 set); 0x0026 gives 38400 bps
// - echo of a baud-changing record's last character uses the new rate
// - memory written one byte per cycle; host changes baud in two records
// - baud divider value 0x0038 selects 115200 bps
// - any non-hex character starts a new record
// - 32-byte instruction buffer at 0xFFFFC0, writable and executable
// - every character echoed; codes below 0x30 restart record assembly
// - records are uppercase hex strings, optionally followed by comments
`ifndef BOOT_LOADER_CONSTS_SVH
`define BOOT_LOADER_CONSTS_SVH

`define IBUF_BASE        24'hFF_FFC0
`define IBUF_BYTES       32
`define IBUF_NOP         16'h4E71
`define BAUD_HI_ADDR     32'hFFFF_F902
`define BAUD_LO_ADDR     32'hFFFF_F903
`define PJSEL_ADDR       32'hFFFF_F43B
`define PJSEL_RST        8'h20
`define PJSEL_TX2_BIT    5
`define BAUD_INIT        16'h0126
`define BAUD_LINK_32K    16'h0126
`define BAUD_LINK_38K    16'h0107
`define CAL_MASK         8'h80
`define CHAR_ACK         8'h40
`define CHAR_MIN         8'h30
`define HDR_NIBBLES      4'h9
`define RST_SP_VEC       32'h0000_1000
`define RST_PC_VEC       32'hFFFF_FF00
`define FRAME_DATA_BITS  4'h8
`define FRAME_STOP_BITS  2'h1
`define ECHO_DEPTH       16

`endif

// file: shared/boot_loader_pkg.sv
// types of the boot-record loader
package boot_loader_pkg;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_EMU    = 2'b01,
        MODE_BOOT   = 2'b10
    } op_mode_t;

    typedef enum logic [3:0] {
        S_OFF   = 4'b0000,
        S_LINK  = 4'b0001,
        S_ACK   = 4'b0010,
        S_ECHO  = 4'b0011,
        S_RX    = 4'b0100,
        S_PROC  = 4'b0101,
        S_WR    = 4'b0110,
        S_BAUD  = 4'b0111,
        S_EXEC  = 4'b1000,
        S_XWAIT = 4'b1001,
        S_GONE  = 4'b1010
    } ld_state_t;

    typedef enum logic [1:0] {
        PH_HDR  = 2'b00,
        PH_DATA = 2'b01,
        PH_SKIP = 2'b10
    } phase_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [7:0]  data;
    } mem_wr_t;

    typedef struct packed {
        logic [3:0] data_bits;
        logic       parity_en;
        logic [1:0] stop_bits;
    } frame_t;

endpackage
